/* File: core/pbsc_top.sv */
// Peripheral bus interface and system configuration registers
`timescale 1ns/1ns
module pbsc_top #(
    parameter int NUM_PERIPH = 15,
    parameter logic [15:0] PRESENT = 16'hfffe,
    parameter logic [15:0] PERIPH_IS8 = 16'h0000
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Clock mode
    input wire logic clk_mode_4x,
    // CPU data bus
    input wire logic cpu_req,
    input wire logic cpu_we,
    input wire logic [15:0] cpu_addr,
    input wire logic [15:0] cpu_wdata,
    output logic [15:0] cpu_rdata,
    output logic cpu_ready,
    // Peripheral bus
    output logic [15:0] pb_sel,
    output logic [7:0] pb_addr,
    output logic pb_we,
    output logic [15:0] pb_wdata,
    output logic pb_strobe,
    input wire logic [15:0] pb_rdata,
    // Interrupt vector from peripheral
    input wire logic pb_vec_valid,
    input wire logic [7:0] pb_vec_data,
    // Reset causes and global reset
    input wire logic por_event,
    input wire logic wd_overflow,
    input wire logic prog_bad_addr,
    output logic global_reset_req,
    // Supply pins
    input wire logic program_voltage_pin,
    input wire logic analog_supply_bad,
    // Clock output pin sources
    input wire logic gpio_out_val,
    input wire logic watchdog_clock,
    input wire logic cpu_clock,
    output logic clock_output_pin,
    output logic clk_out_is_io
);
    ////////////////////////////////////////////////////////////////////////////
    // Parameter checks

    if (NUM_PERIPH < 1 || NUM_PERIPH > pbsc_pkg::NUM_SLOTS - 1)
    begin : g_bad_num
        $error("NUM_PERIPH must lie between 1 and 15");
    end
    if (PRESENT[0])
    begin : g_bad_present
        $error("Slot 0 holds the system registers");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    pbsc_link_if lnk ();
    pbsc_pkg::pbsc_state_type state_ff;
    pbsc_pkg::pbsc_state_type nxt_state;
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;
    logic b2b_ff;
    logic we_ff;
    logic [15:0] addr_ff;
    logic [15:0] cpu_rdata_ff;
    logic [15:0] pb_sel_ff;
    logic [7:0] pb_addr_ff;
    logic pb_we_ff;
    logic [15:0] pb_wdata_ff;
    logic pb_strobe_ff;
    logic grst_ff;
    logic [1:0] clk_sel_ff;
    logic por_ff;
    logic bad_ff;
    logic sw_ff;
    logic wd_ff;
    logic hpo_ff;
    logic rel_ff;
    logic vcca_ff;
    logic vector_read_pending_ff;
    logic [7:0] vec_ff;
    logic clk_pin_ff;
    logic start;
    logic per_start;
    logic per_done;
    logic take_data;
    logic wr_commit;
    logic sw_trig;
    logic bad_trig;
    logic vec_read;
    logic [15:0] sys_rdata;
    logic [15:0] per_rdata;
    logic [3:0] slot_ff;
    logic sys_clk_level;

    ////////////////////////////////////////////////////////////////////////////
    // Divider and decoder

    assign lnk.mode_4x = clk_mode_4x;
    // Decode the live address when idle, the held one during an access
    assign lnk.addr = (state_ff == pbsc_pkg::ST_IDLE) ? cpu_addr : addr_ff;

    pbsc_clkdiv u_div (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .lnk(lnk.div)
    );

    pbsc_decode #(
        .PRESENT(PRESENT)
    ) u_dec (
        .lnk(lnk.dec)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Access sequencer

    // Events of the sequencer
    assign start = (state_ff == pbsc_pkg::ST_IDLE) && cpu_req;
    assign per_start = start && lnk.is_per;
    assign per_done = (state_ff == pbsc_pkg::ST_PER) && (cnt_ff == 4'h0);
    assign take_data = (state_ff == pbsc_pkg::ST_PER) && (cnt_ff == 4'h1);
    assign wr_commit = per_done && we_ff;
    assign slot_ff = addr_ff[11:8];

    // Ready: direct read in the request cycle, others at their last cycle
    always_comb
    begin
        case (state_ff)
            pbsc_pkg::ST_IDLE: cpu_ready = cpu_req && !cpu_we && !lnk.is_per;
            pbsc_pkg::ST_PER: cpu_ready = (cnt_ff == 4'h0);
            pbsc_pkg::ST_DIRW: cpu_ready = 1'b1;
            default: cpu_ready = 1'b0;
        endcase
    end

    // Remaining cycles after the request cycle, minus the ready cycle
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            pbsc_pkg::ST_IDLE:
            begin
                if (per_start)
                begin
                    nxt_state = pbsc_pkg::ST_PER;
                    if (b2b_ff)
                        nxt_cnt = {lnk.period, 1'b0} - 4'h2;
                    else
                        nxt_cnt = {1'b0, lnk.period} - {2'h0, lnk.phase} + {1'b0, lnk.period}
                                  + {3'h0, cpu_we} - 4'h2;
                end
                else if (start && cpu_we)
                begin
                    nxt_state = pbsc_pkg::ST_DIRW;
                end
            end
            pbsc_pkg::ST_PER:
            begin
                if (cnt_ff == 4'h0)
                    nxt_state = pbsc_pkg::ST_IDLE;
                else
                    nxt_cnt = cnt_ff - 4'h1;
            end
            pbsc_pkg::ST_DIRW:
            begin
                nxt_state = pbsc_pkg::ST_IDLE;
            end
            default:
            begin
                nxt_state = pbsc_pkg::ST_IDLE;
                nxt_cnt = 4'h0;
            end
        endcase
    end

    // State and counter
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= pbsc_pkg::ST_IDLE;
            cnt_ff <= 4'h0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // A peripheral access that follows straight on from another
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            b2b_ff <= 1'b0;
        else if (per_done)
            b2b_ff <= 1'b1;
        else if (state_ff == pbsc_pkg::ST_IDLE)
            b2b_ff <= 1'b0;
    end

    // Request capture
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            we_ff <= 1'b0;
            addr_ff <= 16'h0000;
        end
        else if (per_start)
        begin
            we_ff <= cpu_we;
            addr_ff <= cpu_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Peripheral bus drive

    // Select, address and write data held for the whole access
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pb_sel_ff <= 16'h0000;
            pb_addr_ff <= 8'h00;
            pb_we_ff <= 1'b0;
            pb_wdata_ff <= 16'h0000;
        end
        else if (per_start)
        begin
            pb_sel_ff <= lnk.per_sel & PRESENT;
            pb_addr_ff <= {cpu_addr[7:1], 1'b0};
            pb_we_ff <= cpu_we;
            if (PERIPH_IS8[cpu_addr[11:8]])
                pb_wdata_ff <= {8'h00, cpu_wdata[7:0]};
            else
                pb_wdata_ff <= cpu_wdata;
        end
        else if (per_done)
        begin
            pb_sel_ff <= 16'h0000;
            pb_we_ff <= 1'b0;
        end
    end

    // Transfer strobe in the last cycle, ending on the peripheral edge for reads, one cycle after it for writes; back to back, aligned as the access before
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            pb_strobe_ff <= 1'b0;
        else
            pb_strobe_ff <= take_data;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data

    // System register read image, reserved bits as zero
    always_comb
    begin
        sys_rdata = 16'h0000;
        if (lnk.sel_ctl)
            sys_rdata[pbsc_pkg::CTL_CLK_HI:pbsc_pkg::CTL_CLK_LO] = clk_sel_ff;
        if (lnk.sel_sts)
        begin
            sys_rdata[pbsc_pkg::STS_POR] = por_ff;
            sys_rdata[pbsc_pkg::STS_BAD] = bad_ff;
            sys_rdata[pbsc_pkg::STS_SW] = sw_ff;
            sys_rdata[pbsc_pkg::STS_WD] = wd_ff;
            sys_rdata[pbsc_pkg::STS_HPO] = hpo_ff;
            sys_rdata[pbsc_pkg::STS_VCCA] = vcca_ff;
            sys_rdata[pbsc_pkg::STS_VEC] = vector_read_pending_ff;
        end
        if (lnk.sel_vec)
            sys_rdata = {8'h00, vec_ff};
    end

    // Byte-wide peripherals read in the low byte
    assign per_rdata = PERIPH_IS8[slot_ff] ? {8'h00, pb_rdata[7:0]} : pb_rdata;

    // Read data caught the cycle before ready; an absent slot reads the empty system image
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            cpu_rdata_ff <= 16'h0000;
        else if (take_data && !we_ff)
            cpu_rdata_ff <= (slot_ff == pbsc_pkg::SYS_SLOT || pb_sel_ff == 16'h0000) ? sys_rdata : per_rdata;
    end

    ////////////////////////////////////////////////////////////////////////////
    // System control register

    // Soft reset on any pair other than the no-action code
    assign sw_trig = wr_commit && lnk.sel_ctl
                     && (rst_pair(pb_wdata_ff) != pbsc_pkg::RST_NO_ACTION);
    assign bad_trig = (per_start && lnk.bad_addr) || prog_bad_addr;
    assign vec_read = per_done && !we_ff && lnk.sel_vec;

    // Soft reset pair from the held write data, passed in so the assign sees it change
    function automatic logic [1:0] rst_pair(input logic [15:0] w);
        rst_pair = w[pbsc_pkg::CTL_RST_HI:pbsc_pkg::CTL_RST_LO];
    endfunction : rst_pair

    // Clock select field
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            clk_sel_ff <= pbsc_pkg::CLK_SEL_RESET;
        else if (wr_commit && lnk.sel_ctl)
            clk_sel_ff <= pb_wdata_ff[pbsc_pkg::CTL_CLK_HI:pbsc_pkg::CTL_CLK_LO];
    end

    // Global reset request pulse
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            grst_ff <= 1'b0;
        else
            grst_ff <= sw_trig || bad_trig;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset cause flags, kept through reset

    // Set wins over a clear-by-one write
    always_ff @(posedge sys_clk)
    begin
        if (por_event)
            por_ff <= 1'b1;
        else if (wr_commit && lnk.sel_sts && pb_wdata_ff[pbsc_pkg::STS_POR])
            por_ff <= 1'b0;
        if (bad_trig)
            bad_ff <= 1'b1;
        else if (wr_commit && lnk.sel_sts && pb_wdata_ff[pbsc_pkg::STS_BAD])
            bad_ff <= 1'b0;
        if (sw_trig)
            sw_ff <= 1'b1;
        else if (wr_commit && lnk.sel_sts && pb_wdata_ff[pbsc_pkg::STS_SW])
            sw_ff <= 1'b0;
        if (wd_overflow)
            wd_ff <= 1'b1;
        else if (wr_commit && lnk.sel_sts && pb_wdata_ff[pbsc_pkg::STS_WD])
            wd_ff <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Protect override and analog supply

    // Pin caught once on the first edge after reset release
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rel_ff <= 1'b0;
            hpo_ff <= 1'b0;
        end
        else if (!rel_ff)
        begin
            rel_ff <= 1'b1;
            hpo_ff <= program_voltage_pin;
        end
        else if (!program_voltage_pin)
            hpo_ff <= 1'b0;
        else if (wr_commit && lnk.sel_sts && pb_wdata_ff[pbsc_pkg::STS_HPO])
            hpo_ff <= 1'b0;
    end

    // Supply status follows its pin
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            vcca_ff <= pbsc_pkg::STS_VCCA_RESET;
        else
            vcca_ff <= analog_supply_bad;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt vector latch

    // Offset from the acknowledged peripheral
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            vec_ff <= pbsc_pkg::VEC_RESET;
        else if (pb_vec_valid)
            vec_ff <= pb_vec_data;
    end

    // Pending flag, a new vector wins over the read that clears it
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            vector_read_pending_ff <= pbsc_pkg::STS_VEC_RESET;
        else if (pb_vec_valid)
            vector_read_pending_ff <= 1'b1;
        else if (vec_read)
            vector_read_pending_ff <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock output pin

    // Peripheral clock high for the first half of its period
    assign sys_clk_level = ({lnk.phase, 1'b0} < lnk.period);

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            clk_pin_ff <= 1'b0;
        else
        begin
            case (clk_sel_ff)
                pbsc_pkg::CK_IO: clk_pin_ff <= gpio_out_val;
                pbsc_pkg::CK_WDOG: clk_pin_ff <= watchdog_clock;
                pbsc_pkg::CK_SYS: clk_pin_ff <= sys_clk_level;
                pbsc_pkg::CK_CPU: clk_pin_ff <= cpu_clock;
                default: clk_pin_ff <= 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign cpu_rdata = cpu_rdata_ff;
    assign pb_sel = pb_sel_ff;
    assign pb_addr = pb_addr_ff;
    assign pb_we = pb_we_ff;
    assign pb_wdata = pb_wdata_ff;
    assign pb_strobe = pb_strobe_ff;
    assign global_reset_req = grst_ff;
    assign clock_output_pin = clk_pin_ff;
    assign clk_out_is_io = (clk_sel_ff == pbsc_pkg::CK_IO);
endmodule : pbsc_top

/* File: core/pbsc_pkg.sv */
// Package with the constants, codes and types of the peripheral bus and system block
package pbsc_pkg;
    // Address map of the peripheral region and system registers
    localparam logic [3:0] PER_REGION = 4'h7;
    localparam logic [3:0] SYS_SLOT = 4'h0;
    localparam logic [15:0] SYS_CTL_ADDR = 16'h7018;
    localparam logic [15:0] SYS_STS_ADDR = 16'h701a;
    localparam logic [15:0] SYS_VEC_ADDR = 16'h701e;
    localparam int NUM_SLOTS = 16;
    // Control register field positions and reset values
    localparam int CTL_RST_HI = 15;
    localparam int CTL_RST_LO = 14;
    localparam int CTL_CLK_HI = 7;
    localparam int CTL_CLK_LO = 6;
    localparam logic [1:0] RST_NO_ACTION = 2'h1;
    localparam logic [1:0] CLK_SEL_RESET = 2'h0;
    // Status register field positions and reset values
    localparam int STS_POR = 15;
    localparam int STS_BAD = 12;
    localparam int STS_SW = 10;
    localparam int STS_WD = 9;
    localparam int STS_HPO = 5;
    localparam int STS_VCCA = 3;
    localparam int STS_VEC = 0;
    localparam logic STS_VCCA_RESET = 1'h1;
    localparam logic STS_VEC_RESET = 1'h0;
    localparam logic [7:0] VEC_RESET = 8'h00;
    // Clock output pin functions
    localparam logic [1:0] CK_IO = 2'h0;
    localparam logic [1:0] CK_WDOG = 2'h1;
    localparam logic [1:0] CK_SYS = 2'h2;
    localparam logic [1:0] CK_CPU = 2'h3;
    // Timing counts in CPU cycles
    localparam logic [2:0] PERIOD_2X = 3'h2;
    localparam logic [2:0] PERIOD_4X = 3'h4;
    localparam int DIR_WR_CYCLES = 2;
    // Access sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_PER = 3'b010,
        ST_DIRW = 3'b100
    } pbsc_state_type;
endpackage : pbsc_pkg

/* File: core/pbsc_link_if.sv */
// Interface joining the core with its clock divider and address decoder
`timescale 1ns/1ns
interface pbsc_link_if;
    logic mode_4x;
    logic [2:0] period;
    logic [1:0] phase;
    logic pclk_en;
    logic [15:0] addr;
    logic is_per;
    logic [15:0] per_sel;
    logic sel_ctl;
    logic sel_sts;
    logic sel_vec;
    logic bad_addr;
    modport div (input mode_4x, output period, phase, pclk_en);
    modport dec (input addr, output is_per, per_sel, sel_ctl, sel_sts, sel_vec, bad_addr);
    modport core (output mode_4x, addr, input period, phase, pclk_en, is_per, per_sel, sel_ctl, sel_sts,
        sel_vec, bad_addr);
endinterface : pbsc_link_if

/* File: core/pbsc_clkdiv.sv */
// Peripheral clock phase counter and enable pulse
`timescale 1ns/1ns
module pbsc_clkdiv (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Link to core
    pbsc_link_if.div lnk
);
    logic [1:0] phase_ff;
    logic [2:0] period;

    // Divide by two or by four
    assign period = lnk.mode_4x ? pbsc_pkg::PERIOD_4X : pbsc_pkg::PERIOD_2X;

    // Phase 0 is the cycle right after a peripheral clock edge
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            phase_ff <= 2'h0;
        else if ({1'b0, phase_ff} >= period - 3'h1)
            phase_ff <= 2'h0;
        else
            phase_ff <= phase_ff + 2'h1;
    end

    assign lnk.period = period;
    assign lnk.phase = phase_ff;
    assign lnk.pclk_en = ({1'b0, phase_ff} == period - 3'h1);
endmodule : pbsc_clkdiv

/* File: core/pbsc_decode.sv */
// Address decoder for the peripheral region and system registers
`timescale 1ns/1ns
module pbsc_decode #(
    parameter logic [15:0] PRESENT = 16'hfffe
) (
    // Link to core
    pbsc_link_if.dec lnk
);
    // Word match with address bit 0 ignored
    function automatic logic word_hit(input logic [15:0] a, input logic [15:0] r);
        word_hit = (a[15:1] == r[15:1]);
    endfunction : word_hit

    logic [3:0] slot;
    logic in_sys;

    assign lnk.is_per = (lnk.addr[15:12] == pbsc_pkg::PER_REGION);
    assign slot = lnk.addr[11:8];
    assign in_sys = lnk.is_per && (slot == pbsc_pkg::SYS_SLOT);
    // System registers
    assign lnk.sel_ctl = word_hit(lnk.addr, pbsc_pkg::SYS_CTL_ADDR);
    assign lnk.sel_sts = word_hit(lnk.addr, pbsc_pkg::SYS_STS_ADDR);
    assign lnk.sel_vec = word_hit(lnk.addr, pbsc_pkg::SYS_VEC_ADDR);
    // One select per peripheral slot, system slot kept internal
    assign lnk.per_sel = (lnk.is_per && !in_sys) ? (16'h0001 << slot) : 16'h0000;
    // Unimplemented location inside the region
    assign lnk.bad_addr = in_sys ? !(lnk.sel_ctl || lnk.sel_sts || lnk.sel_vec)
                                 : (lnk.is_per && !PRESENT[slot]);
endmodule : pbsc_decode

/* File: verif/pbsc_props.sv */
// Port checker of the peripheral bus and system block
`timescale 1ns/1ns
module pbsc_props (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // CPU side
    input wire logic clk_mode_4x,
    input wire logic cpu_req,
    input wire logic cpu_we,
    input wire logic [15:0] cpu_addr,
    input wire logic [15:0] cpu_wdata,
    input wire logic [15:0] cpu_rdata,
    input wire logic cpu_ready,
    // Peripheral and system side
    input wire logic [15:0] pb_sel,
    input wire logic pb_strobe,
    input wire logic global_reset_req,
    input wire logic gpio_out_val,
    input wire logic clock_output_pin,
    input wire logic clk_out_is_io
);
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic [3:0] wait_ff;
    wire in_reg = cpu_addr[15:12] == 4'h7;
    wire ctl_wr = cpu_ready && cpu_we && cpu_addr[15:1] == 15'h380c;
    ////////////////////////////////////////////////////////////////////////
    // Cycles already spent in the open access
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            wait_ff <= 4'h0;
        else
            wait_ff <= (cpu_req && !cpu_ready) ? wait_ff + 4'h1 : 4'h0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Access timing and handshake
    per_cycles_a: assert property (cpu_ready && in_reg |-> int'(wait_ff) >= (clk_mode_4x ? 4 : 2) + int'(cpu_we)
        && int'(wait_ff) <= (clk_mode_4x ? 7 : 3) + int'(cpu_we)) else $error("peripheral access length wrong");
    dir_read_a: assert property (cpu_req && !cpu_we && !in_reg |-> cpu_ready) else $error("direct read late");
    dir_write_a: assert property (cpu_req && cpu_we && !in_reg && !cpu_ready |=> cpu_ready)
        else $error("direct write late");
    sel_hold_a: assert property (pb_sel != 16'h0 && !cpu_ready |=> $stable(pb_sel)) else $error("select moved");
    strobe_ready_a: assert property (pb_strobe |-> cpu_ready && in_reg) else $error("strobe off ready");
    sel_onehot_a: assert property ($onehot0(pb_sel)) else $error("several slots selected");
    // Register side effects
    vec_upper_a: assert property (cpu_ready && !cpu_we && cpu_addr[15:1] == 15'h380f |-> cpu_rdata[15:8] == 8'h00)
        else $error("vector upper byte set");
    soft_reset_a: assert property (ctl_wr && cpu_wdata[15:14] != 2'b01 |=> global_reset_req)
        else $error("reset request missing");
    no_reset_a: assert property (ctl_wr && cpu_wdata[15:14] == 2'b01 |=> !global_reset_req)
        else $error("spurious reset request");
    clock_output_pin_io_a: assert property (clk_out_is_io && $past(clk_out_is_io) && $past(rst_n)
        |-> clock_output_pin == $past(gpio_out_val)) else $error("io pin value wrong");
    // Main scenarios
    cover property (cpu_ready && in_reg && wait_ff == 4'h7);
    cover property (global_reset_req);
    cover property (pb_strobe && cpu_we);
endmodule : pbsc_props
bind pbsc_top pbsc_props u_pbsc_props (.sys_clk, .rst_n, .clk_mode_4x, .cpu_req, .cpu_we, .cpu_addr, .cpu_wdata,
    .cpu_rdata, .cpu_ready, .pb_sel, .pb_strobe, .global_reset_req, .gpio_out_val, .clock_output_pin, .clk_out_is_io);

/* File: verif/pbsc_periph_model.sv */
// Peripheral bus partner: one word per slot and an interrupt vector source
`timescale 1ns/1ns
module pbsc_periph_model #(
    parameter logic [7:0] VEC_OFFSET = 8'h2c
) (
    // Clock
    input wire logic sys_clk,
    // Peripheral bus
    input wire logic [15:0] pb_sel,
    input wire logic pb_we,
    input wire logic [15:0] pb_wdata,
    input wire logic pb_strobe,
    output logic [15:0] pb_rdata,
    // Interrupt acknowledge and vector
    input wire logic int_ack,
    output logic pb_vec_valid,
    output logic [7:0] pb_vec_data
);
    logic [15:0] word_ff [16];
    logic [15:0] last_ff = 16'h5a5a;
    ////////////////////////////////////////////////////////////////////////
    // Store on strobe; vector offers offset on acknowledge, junk otherwise
    always_ff @(posedge sys_clk)
    begin
        for (int i = 0; i < 16; i++)
            if (pb_strobe && pb_we && pb_sel[i])
                word_ff[i] <= pb_wdata;
        last_ff <= pb_rdata;
        pb_vec_valid <= int_ack;
        pb_vec_data <= int_ack ? VEC_OFFSET : last_ff[7:0];
    end
    // Selected slot drives its word, a released bus toggles every cycle
    always_comb
    begin
        pb_rdata = ~last_ff;
        for (int i = 0; i < 16; i++)
            if (pb_sel[i])
                pb_rdata = word_ff[i];
    end
endmodule : pbsc_periph_model

/* File: verif/pbsc_tb.sv */
// Self-checking bench of the peripheral bus and system block
`timescale 1ns/1ns
module testbench;
    logic sys_clk, rst_n, clk_mode_4x, cpu_req, cpu_we, cpu_ready, pb_we, pb_strobe, int_ack, pb_vec_valid;
    logic por_event, wd_overflow, prog_bad_addr, global_reset_req, program_voltage_pin, analog_supply_bad;
    logic gpio_out_val, watchdog_clock, cpu_clock, clock_output_pin, clk_out_is_io;
    logic [15:0] cpu_addr, cpu_wdata, cpu_rdata, pb_sel, pb_wdata, pb_rdata, rd;
    logic [7:0] pb_addr, pb_vec_data;
    int n_mismatch, check_count, n;
    pbsc_top #(.PRESENT(16'h7ffe), .PERIPH_IS8(16'h0004)) u_pbsc_top (.sys_clk, .rst_n, .clk_mode_4x, .cpu_req,
        .cpu_we, .cpu_addr, .cpu_wdata, .cpu_rdata, .cpu_ready, .pb_sel, .pb_addr, .pb_we, .pb_wdata, .pb_strobe,
        .pb_rdata, .pb_vec_valid, .pb_vec_data, .por_event, .wd_overflow, .prog_bad_addr, .global_reset_req,
        .program_voltage_pin, .analog_supply_bad, .gpio_out_val, .watchdog_clock, .cpu_clock, .clock_output_pin,
        .clk_out_is_io);
    pbsc_periph_model #(.VEC_OFFSET(8'h2c)) u_pbsc_periph_model (.sys_clk, .pb_sel, .pb_we, .pb_wdata, .pb_strobe,
        .pb_rdata, .int_ack, .pb_vec_valid, .pb_vec_data);
    ////////////////////////////////////////////////////////////////////////
    // Clock
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Verdict and end of run
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test
    // Compare one value
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One CPU access; n counts cycles with the request cycle as 1, request left up
    task automatic acc(input logic we, input logic [15:0] a, input logic [15:0] d);
        cpu_req = 1'b1;
        cpu_we = we;
        cpu_addr = a;
        cpu_wdata = d;
        for (n = 1; n < 20; n++)
        begin
            @(negedge sys_clk);
            if (cpu_ready === 1'b1)
                break;
            @(posedge sys_clk);
        end
        rd = cpu_rdata;
        chk("ready wait", 16'h0, 16'(n == 20));
        if (n == 20)
            end_of_test();
        @(posedge sys_clk);
        #1;
    endtask : acc
    // Drop the request for k cycles
    task automatic idle(input int k);
        cpu_req = 1'b0;
        gpio_out_val = ~gpio_out_val;
        repeat (k) @(posedge sys_clk);
        #1;
    endtask : idle
    ////////////////////////////////////////////////////////////////////////
    // Single accesses at every divider phase, then back to back
    task automatic t_timing(input logic m);
        int p;
        int mask;
        clk_mode_4x = m;
        p = m ? 4 : 2;
        for (int we = 0; we < 2; we++)
        begin
            mask = 0;
            for (int g = 1; g <= 5; g++)
            begin
                idle(g);
                acc(we[0], 16'h7302, 16'h1234);
                mask |= 1 << n;
            end
            chk("single cycles", 16'((((1 << (2 * p + 1)) - 1) & ~((1 << (p + 1)) - 1)) << we), 16'(mask));
            acc(we[0], 16'h7302, 16'h1234);
            chk("back to back cycles", 16'(2 * p), 16'(n));
        end
        idle(1);
        $display("timing test done");
    endtask : t_timing
    // Data paths, direct accesses and an absent slot
    task automatic t_data();
        acc(1'b1, 16'h7305, 16'hbeef);
        acc(1'b0, 16'h7304, 16'h0);
        chk("odd address word", 16'hbeef, rd);
        acc(1'b1, 16'h7200, 16'hab12);
        acc(1'b0, 16'h7201, 16'h0);
        chk("byte slot word", 16'h0012, rd);
        acc(1'b0, 16'h1000, 16'h0);
        chk("direct read cycles", 16'h1, 16'(n));
        acc(1'b1, 16'h1000, 16'h0);
        chk("direct write cycles", 16'h2, 16'(n));
        acc(1'b0, 16'h7f00, 16'h0);
        chk("absent slot data", 16'h0, rd);
        $display("data test done");
    endtask : t_data
    // Control, status and vector registers of the system slot
    task automatic t_sys();
        acc(1'b1, 16'h7019, 16'h4080);
        chk("no action reset", 16'h0, 16'(global_reset_req));
        acc(1'b0, 16'h7018, 16'h0);
        chk("control read", 16'h0080, rd);
        chk("clock pin io", 16'h0, 16'(clk_out_is_io));
        acc(1'b1, 16'h7018, 16'h8080);
        chk("soft reset", 16'h1, 16'(global_reset_req));
        idle(1);
        int_ack = 1'b1;
        idle(1);
        int_ack = 1'b0;
        acc(1'b0, 16'h701a, 16'h0);
        chk("status flags", 16'h9401, rd & 16'h9401);
        acc(1'b0, 16'h701e, 16'h0);
        chk("vector", 16'h002c, rd);
        acc(1'b1, 16'h701a, 16'h8400);
        acc(1'b0, 16'h701a, 16'h0);
        chk("status cleared", 16'h1008, rd & 16'h9409);
        idle(1);
        $display("system test done");
    endtask : t_sys
    // Reset, scenarios and verdict
    initial
    begin
        {cpu_req, cpu_we, int_ack, wd_overflow, prog_bad_addr, program_voltage_pin} = '0;
        {gpio_out_val, watchdog_clock, cpu_clock, clk_mode_4x} = '0;
        cpu_addr = 16'h0;
        cpu_wdata = 16'h0;
        analog_supply_bad = 1'b1;
        por_event = 1'b1;
        n_mismatch = 0;
        check_count = 0;
        rst_n = 1'b0;
        repeat (12) @(posedge sys_clk);
        #1;
        por_event = 1'b0;
        rst_n = 1'b1;
        @(posedge sys_clk);
        #1;
        t_timing(1'b0);
        t_timing(1'b1);
        t_data();
        t_sys();
        end_of_test();
    end
endmodule : testbench
